// ===== core_pkg.sv
package core_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int                  INSTR_CLOCKS = 4;
    localparam int                  PHASE_W      = $clog2(INSTR_CLOCKS);
    localparam logic [PHASE_W-1:0]  LAST_PHASE   = PHASE_W'(INSTR_CLOCKS - 1);
    localparam logic [PHASE_W-1:0]  PHASE_RESET  = '0;

    // ------------------------------------------------------------------
    // Instruction word layout
    // ------------------------------------------------------------------
    localparam int                  WORD_W       = 16;
    localparam int                  DATA_W       = 8;
    localparam int                  OPC_LSB      = 11;
    localparam int                  OPC_MSB      = 15;
    localparam int                  BIT_LSB      = 8;
    localparam int                  BIT_MSB      = 10;

    // ------------------------------------------------------------------
    // Data memory map and reset values
    // ------------------------------------------------------------------
    localparam int                  PC_LOW_INDEX = 0;
    localparam logic [DATA_W-1:0]   PC_RESET     = 8'h00;
    localparam logic [DATA_W-1:0]   ACC_RESET    = 8'h00;
    localparam logic [DATA_W-1:0]   RAM_RESET    = 8'h00;
    localparam logic                FLAG_RESET   = 1'b0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NOP          = 5'h00, OP_XFER_A_MEM   = 5'h01,
        OP_XFER_MEM_A   = 5'h02, OP_XFER_A_IMM   = 5'h03,
        OP_ADD_A_MEM    = 5'h04, OP_ADD_A_IMM    = 5'h05,
        OP_SUB_A_MEM    = 5'h06, OP_SUB_A_IMM    = 5'h07,
        OP_ADD_ONE_MEM  = 5'h08, OP_ADD_ONE_ACC  = 5'h09,
        OP_SUB_ONE_MEM  = 5'h0A, OP_SUB_ONE_ACC  = 5'h0B,
        OP_AND_A_MEM    = 5'h0C, OP_OR_A_MEM     = 5'h0D,
        OP_XOR_A_MEM    = 5'h0E, OP_INVERT_MEM   = 5'h0F,
        OP_INVERT_ACC   = 5'h10, OP_ROT_RIGHT    = 5'h11,
        OP_ROT_LEFT     = 5'h12, OP_ROT_RIGHT_C  = 5'h13,
        OP_ROT_LEFT_C   = 5'h14, OP_JUMP         = 5'h15,
        OP_CALL         = 5'h16, OP_SUB_EXIT     = 5'h17,
        OP_IRQ_EXIT     = 5'h18, OP_SKIP_ZERO    = 5'h19,
        OP_SKIP_BIT_CLR = 5'h1A, OP_SKIP_BIT_SET = 5'h1B,
        OP_SET_BIT      = 5'h1C, OP_CLEAR_BIT    = 5'h1D,
        OP_TABLE_READ   = 5'h1E, OP_CLEAR_MEM    = 5'h1F
    } op_t;

    typedef enum logic [3:0] {
        ALU_PASS = 4'h0, ALU_ADD = 4'h1, ALU_SUB  = 4'h2, ALU_INC  = 4'h3,
        ALU_DEC  = 4'h4, ALU_AND = 4'h5, ALU_OR   = 4'h6, ALU_XOR  = 4'h7,
        ALU_INV  = 4'h8, ALU_ROR = 4'h9, ALU_ROL  = 4'hA, ALU_RORC = 4'hB,
        ALU_ROLC = 4'hC
    } alu_op_t;

    typedef enum logic [1:0] {
        ST_EXEC  = 2'b01,
        ST_FLUSH = 2'b10
    } core_state_t;

endpackage : core_pkg

// ===== alu_if.sv
`timescale 1ns/1ps
interface alu_if;
    import core_pkg::*;

    alu_op_t            op;
    logic [DATA_W-1:0]  a;
    logic [DATA_W-1:0]  b;
    logic               cin;
    logic [DATA_W-1:0]  result;
    logic               cout;
    logic               zero;

    modport core (output op, a, b, cin, input result, cout, zero);
    modport unit (input op, a, b, cin, output result, cout, zero);

endinterface : alu_if

// ===== alu_unit.sv
`timescale 1ns/1ps
module alu_unit
    import core_pkg::*;
(
    alu_if.unit bus
);

    logic [DATA_W:0] sum;
    logic [DATA_W:0] diff;

    assign sum  = {1'b0, bus.a} + {1'b0, bus.b};
    assign diff = {1'b0, bus.a} - {1'b0, bus.b};

    // ------------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------------
    always_comb
    begin
        bus.result = bus.a;
        bus.cout   = bus.cin;
        case (bus.op)
            ALU_PASS: bus.result = bus.a;
            ALU_ADD:
            begin
                bus.result = sum[DATA_W-1:0];
                bus.cout   = sum[DATA_W];
            end
            ALU_SUB:
            begin
                // Carry set means a borrow happened
                bus.result = diff[DATA_W-1:0];
                bus.cout   = diff[DATA_W];
            end
            ALU_INC:  bus.result = bus.a + 8'h01;
            ALU_DEC:  bus.result = bus.a - 8'h01;
            ALU_AND:  bus.result = bus.a & bus.b;
            ALU_OR:   bus.result = bus.a | bus.b;
            ALU_XOR:  bus.result = bus.a ^ bus.b;
            ALU_INV:  bus.result = ~bus.a;
            ALU_ROR:  bus.result = {bus.a[0], bus.a[DATA_W-1:1]};
            ALU_ROL:  bus.result = {bus.a[DATA_W-2:0], bus.a[DATA_W-1]};
            ALU_RORC:
            begin
                bus.result = {bus.cin, bus.a[DATA_W-1:1]};
                bus.cout   = bus.a[0];
            end
            ALU_ROLC:
            begin
                bus.result = {bus.a[DATA_W-2:0], bus.cin};
                bus.cout   = bus.a[DATA_W-1];
            end
            default:  bus.result = bus.a;
        endcase
    end

    assign bus.zero = (bus.result == 8'h00);

endmodule : alu_unit

// ===== instruction_timing_execution.sv
`timescale 1ns/1ps
module instruction_timing_execution
    import core_pkg::*;
#(
    parameter int DATA_DEPTH = 16
)
(
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic [WORD_W-1:0]  progData,
    output      logic [DATA_W-1:0]  progAddr,
    output      logic               instrDone,
    output      logic [DATA_W-1:0]  acc,
    output      logic               carryFlag,
    output      logic               zeroFlag,
    output      logic               globalIrqEnable
);

    localparam int ADDR_W = $clog2(DATA_DEPTH);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        core_state_t                        state;
        logic [PHASE_W-1:0]                 phase;
        logic [DATA_W-1:0]                  pc;
        logic [DATA_W-1:0]                  fetchAddr;
        logic [DATA_W-1:0]                  retAddr;
        logic [DATA_W-1:0]                  acc;
        logic                               carry;
        logic                               zero;
        logic                               gie;
        logic                               tabRead;
        logic                               done;
        logic [DATA_DEPTH-1:0][DATA_W-1:0]  ram;
    } core_t;

    core_t                  s;
    core_t                  next_s;
    alu_if                  alu ();

    op_t                    op;
    logic [2:0]             bitSel;
    logic [DATA_W-1:0]      operand;
    logic [ADDR_W-1:0]      idx;
    logic [DATA_W-1:0]      memRd;
    logic [DATA_W-1:0]      bitMask;
    logic                   wrAcc;
    logic                   wrMem;
    logic                   updC;
    logic                   updZ;
    logic                   longOp;
    logic                   skipTest;
    logic                   skipCond;
    logic                   pcWrite;
    logic                   skipNow;
    logic                   extraNow;
    logic                   execNow;

    alu_unit u_alu (
        .bus (alu)
    );

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign op      = op_t'(progData[OPC_MSB:OPC_LSB]);
    assign bitSel  = progData[BIT_MSB:BIT_LSB];
    assign operand = progData[DATA_W-1:0];
    assign idx     = operand[ADDR_W-1:0];
    // Location zero aliases the program counter low byte
    assign memRd   = (idx == ADDR_W'(PC_LOW_INDEX)) ? s.pc : s.ram[idx];
    assign bitMask = 8'h01 << bitSel;

    always_comb
    begin
        alu.op   = ALU_PASS;
        alu.a    = s.acc;
        alu.b    = memRd;
        alu.cin  = s.carry;
        wrAcc    = 1'b0;
        wrMem    = 1'b0;
        updC     = 1'b0;
        updZ     = 1'b0;
        longOp   = 1'b0;
        skipTest = 1'b0;
        skipCond = 1'b0;
        case (op)
            OP_NOP:          wrAcc = 1'b0;
            OP_XFER_A_MEM:   begin alu.a = memRd; wrAcc = 1'b1; end
            OP_XFER_MEM_A:   wrMem = 1'b1;
            OP_XFER_A_IMM:   begin alu.a = operand; wrAcc = 1'b1; end
            OP_ADD_A_MEM, OP_ADD_A_IMM, OP_SUB_A_MEM, OP_SUB_A_IMM:
            begin
                alu.op = (op == OP_ADD_A_MEM || op == OP_ADD_A_IMM) ? ALU_ADD : ALU_SUB;
                if (op == OP_ADD_A_IMM || op == OP_SUB_A_IMM)
                    alu.b = operand;
                wrAcc = 1'b1;
                updC  = 1'b1;
                updZ  = 1'b1;
            end
            OP_ADD_ONE_MEM, OP_ADD_ONE_ACC, OP_SUB_ONE_MEM, OP_SUB_ONE_ACC:
            begin
                alu.op = (op == OP_ADD_ONE_MEM || op == OP_ADD_ONE_ACC) ? ALU_INC : ALU_DEC;
                alu.a  = memRd;
                wrMem  = (op == OP_ADD_ONE_MEM || op == OP_SUB_ONE_MEM);
                wrAcc  = !wrMem;
                updZ   = 1'b1;
            end
            OP_AND_A_MEM:    begin alu.op = ALU_AND; wrAcc = 1'b1; updZ = 1'b1; end
            OP_OR_A_MEM:     begin alu.op = ALU_OR; wrAcc = 1'b1; updZ = 1'b1; end
            OP_XOR_A_MEM:    begin alu.op = ALU_XOR; wrAcc = 1'b1; updZ = 1'b1; end
            OP_INVERT_MEM, OP_INVERT_ACC:
            begin
                alu.op = ALU_INV;
                alu.a  = memRd;
                wrMem  = (op == OP_INVERT_MEM);
                wrAcc  = (op == OP_INVERT_ACC);
                updZ   = 1'b1;
            end
            OP_ROT_RIGHT:    begin alu.op = ALU_ROR; alu.a = memRd; wrMem = 1'b1; end
            OP_ROT_LEFT:     begin alu.op = ALU_ROL; alu.a = memRd; wrMem = 1'b1; end
            OP_ROT_RIGHT_C:
            begin
                alu.op = ALU_RORC;
                alu.a  = memRd;
                wrMem  = 1'b1;
                updC   = 1'b1;
            end
            OP_ROT_LEFT_C:
            begin
                alu.op = ALU_ROLC;
                alu.a  = memRd;
                wrMem  = 1'b1;
                updC   = 1'b1;
            end
            OP_JUMP, OP_CALL, OP_SUB_EXIT, OP_IRQ_EXIT, OP_TABLE_READ:
                longOp = 1'b1;
            OP_SKIP_ZERO:    begin skipTest = 1'b1; skipCond = (memRd == 8'h00); end
            OP_SKIP_BIT_CLR: begin skipTest = 1'b1; skipCond = !memRd[bitSel]; end
            OP_SKIP_BIT_SET: begin skipTest = 1'b1; skipCond = memRd[bitSel]; end
            // Read-modify-write in one cycle so no other bit can change
            OP_SET_BIT:      begin alu.a = memRd | bitMask; wrMem = 1'b1; end
            OP_CLEAR_BIT:    begin alu.a = memRd & ~bitMask; wrMem = 1'b1; end
            OP_CLEAR_MEM:    begin alu.a = 8'h00; wrMem = 1'b1; end
            default:         wrAcc = 1'b0;
        endcase
    end

    assign pcWrite  = wrMem && (idx == ADDR_W'(PC_LOW_INDEX));
    assign skipNow  = skipTest && skipCond;
    assign extraNow = longOp || pcWrite || skipNow;
    assign execNow  = (s.state == ST_EXEC) && (s.phase == LAST_PHASE);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [DATA_W-1:0] pcNext;
        pcNext = s.pc + 8'h01;
        next_s = s;
        next_s.done = 1'b0;
        // Program data is sampled only in the last clock of the cycle
        next_s.phase = (s.phase == LAST_PHASE) ? PHASE_RESET : s.phase + PHASE_W'(1);
        if (s.phase == LAST_PHASE)
        begin
            case (s.state)
                ST_EXEC:
                begin
                    if (wrAcc)
                        next_s.acc = alu.result;
                    if (updC)
                        next_s.carry = alu.cout;
                    if (updZ)
                        next_s.zero = alu.zero;
                    if (wrMem && !pcWrite)
                        next_s.ram[idx] = alu.result;
                    case (op)
                        OP_JUMP:     pcNext = operand;
                        OP_CALL:
                        begin
                            // Single return slot: nested calls overwrite it
                            next_s.retAddr = s.pc + 8'h01;
                            pcNext = operand;
                        end
                        OP_SUB_EXIT: pcNext = s.retAddr;
                        OP_IRQ_EXIT:
                        begin
                            pcNext = s.retAddr;
                            next_s.gie = 1'b1;
                        end
                        default:     pcNext = pcNext;
                    endcase
                    if (pcWrite)
                        pcNext = alu.result;
                    if (skipNow)
                        pcNext = s.pc + 8'h02;
                    next_s.pc        = pcNext;
                    next_s.tabRead   = (op == OP_TABLE_READ);
                    next_s.fetchAddr = (op == OP_TABLE_READ) ? operand : pcNext;
                    if (extraNow)
                        next_s.state = ST_FLUSH;
                    else
                        next_s.done = 1'b1;
                end
                ST_FLUSH:
                begin
                    if (s.tabRead)
                        next_s.acc = progData[DATA_W-1:0];
                    next_s.tabRead   = 1'b0;
                    next_s.fetchAddr = s.pc;
                    next_s.state     = ST_EXEC;
                    next_s.done      = 1'b1;
                end
                default:     next_s.state = ST_EXEC;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s.state     <= ST_EXEC;
            s.phase     <= PHASE_RESET;
            s.pc        <= PC_RESET;
            s.fetchAddr <= PC_RESET;
            s.retAddr   <= PC_RESET;
            s.acc       <= ACC_RESET;
            s.carry     <= FLAG_RESET;
            s.zero      <= FLAG_RESET;
            s.gie       <= FLAG_RESET;
            s.tabRead   <= FLAG_RESET;
            s.done      <= FLAG_RESET;
            s.ram       <= {DATA_DEPTH{RAM_RESET}};
        end
        else
            s <= next_s;
    end

    assign progAddr        = s.fetchAddr;
    assign instrDone       = s.done;
    assign acc             = s.acc;
    assign carryFlag       = s.carry;
    assign zeroFlag        = s.zero;
    assign globalIrqEnable = s.gie;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic [DATA_W:0] immSum;
    assign immSum = {1'b0, s.acc} + {1'b0, operand};

    sequence seq_flush_cycle;
        (s.state == ST_FLUSH && !s.done) [*4];
    endsequence

    sequence seq_done_exec;
        s.done && s.state == ST_EXEC && s.phase == PHASE_RESET;
    endsequence

    chk_cycle_length: assert property (s.phase == LAST_PHASE |=> s.phase == PHASE_RESET ##3 s.phase == LAST_PHASE) else $error("cycle not four clocks");
    chk_single_cycle: assert property (execNow && !extraNow |=> seq_done_exec) else $error("short instruction not done");
    chk_long_cycle: assert property (execNow && longOp |=> seq_flush_cycle ##1 seq_done_exec) else $error("long instruction not two cycles");
    chk_table_fetch: assert property (execNow && op == OP_TABLE_READ |=> progAddr == $past(operand) ##4 s.acc == $past(progData[DATA_W-1:0])) else $error("table read wrong");
    chk_pc_low_write: assert property (execNow && pcWrite |=> s.pc == $past(alu.result) ##0 seq_flush_cycle) else $error("pc low write not a jump");
    chk_skip_taken: assert property (execNow && skipNow |=> s.pc == $past(s.pc) + 8'h02 ##0 seq_flush_cycle) else $error("taken skip wrong");
    chk_skip_missed: assert property (execNow && skipTest && !skipCond |=> s.state == ST_EXEC && s.pc == $past(s.pc) + 8'h01) else $error("untaken skip wrong");
    chk_imm_transfer: assert property (execNow && op == OP_XFER_A_IMM |=> s.acc == $past(operand)) else $error("immediate transfer wrong");
    chk_store_transfer: assert property (execNow && op == OP_XFER_MEM_A && !pcWrite |=> s.ram[$past(idx)] == $past(s.acc)) else $error("store transfer wrong");
    chk_add_carry: assert property (execNow && op == OP_ADD_A_IMM |=> carryFlag == ($past(immSum) > 9'h0FF)) else $error("add carry wrong");
    chk_sub_borrow: assert property (execNow && op == OP_SUB_A_IMM |=> carryFlag == ($past(s.acc) < $past(operand))) else $error("sub borrow wrong");
    chk_inc_acc: assert property (execNow && op == OP_ADD_ONE_ACC |=> s.acc == $past(memRd) + 8'h01) else $error("increment wrong");
    chk_dec_mem: assert property (execNow && op == OP_SUB_ONE_MEM && !pcWrite |=> s.ram[$past(idx)] == $past(memRd) - 8'h01) else $error("decrement wrong");
    chk_logic_zero: assert property (execNow && (op == OP_AND_A_MEM || op == OP_XOR_A_MEM) |=> zeroFlag == (s.acc == 8'h00)) else $error("logic zero flag wrong");
    chk_rotate_carry: assert property (execNow && op == OP_ROT_RIGHT_C |=> carryFlag == $past(memRd[0])) else $error("rotate carry wrong");
    chk_call_save: assert property (execNow && op == OP_CALL |=> s.retAddr == $past(s.pc) + 8'h01 && s.pc == $past(operand)) else $error("call save wrong");
    chk_return_addr: assert property (execNow && op == OP_SUB_EXIT |=> s.pc == $past(s.retAddr) && s.gie == $past(s.gie)) else $error("return wrong");
    chk_bit_skip: assert property (execNow && op == OP_SKIP_BIT_CLR |=> (s.state == ST_FLUSH) == !$past(memRd[bitSel])) else $error("bit test wrong");
    chk_bit_set: assert property (execNow && op == OP_SET_BIT && !pcWrite |=> s.ram[$past(idx)] == ($past(memRd) | $past(bitMask))) else $error("bit set wrong");
    chk_irq_exit: assert property (execNow && op == OP_IRQ_EXIT |=> globalIrqEnable && s.pc == $past(s.retAddr)) else $error("irq exit wrong");

endmodule : instruction_timing_execution

// ===== program_memory.sv
`timescale 1ns/1ps
module program_memory
    import core_pkg::*;
(
    input  wire logic [DATA_W-1:0]  progAddr,
    output      logic [WORD_W-1:0]  progData
);
    // ------------------------------------------------------------
    // Words loaded by the bench; every address always answers
    // ------------------------------------------------------------
    logic [WORD_W-1:0]  words [256];

    assign progData = words[progAddr];
endmodule : program_memory

// ===== instruction_timing_execution_tb.sv
`timescale 1ns/1ps
module instruction_timing_execution_tb;
    import core_pkg::*;

    typedef struct {
        int                 gap;
        logic [DATA_W-1:0]  pc;
        logic [DATA_W-1:0]  a;
        logic               c;
        logic               z;
        logic               irq;
    } expect_t;

    logic               clk = 1'b0;
    logic               reset = 1'b1;
    logic [WORD_W-1:0]  progData;
    logic [DATA_W-1:0]  progAddr;
    logic [DATA_W-1:0]  acc;
    logic               instrDone;
    logic               carryFlag;
    logic               zeroFlag;
    logic               globalIrqEnable;
    expect_t            pending[$];
    expect_t            e;
    int                 n_fail = 0;
    int                 comparisons = 0;
    int                 gap = 0;
    logic [31:0]        seed = 32'h0000001A;
    logic [DATA_W-1:0]  a, m, r1, r2, r4;
    logic               c, z, irq, hit;

    initial forever #5 clk = ~clk;

    instruction_timing_execution #(.DATA_DEPTH(16)) u_instruction_timing_execution (
        .clk(clk), .reset(reset), .progData(progData), .progAddr(progAddr),
        .instrDone(instrDone), .acc(acc), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
        .globalIrqEnable(globalIrqEnable));

    program_memory u_program_memory (.progAddr(progAddr), .progData(progData));

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xorshift

    task automatic compare(input string what, input logic [15:0] want, input logic [15:0] seen);
        comparisons++;
        if (seen !== want)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask : compare

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    // Gap counts edges between completions, so a 1-cycle instruction shows 4
    always @(negedge clk)
    begin
        gap = reset ? 0 : gap + 1;
        if (!reset && instrDone === 1'b1 && pending.size() > 0)
        begin
            e = pending.pop_front();
            if (e.gap != 0)
                compare("cycles", 16'(e.gap), 16'(gap));
            compare("acc", 16'(e.a), 16'(acc));
            compare("carry", 16'(e.c), 16'(carryFlag));
            compare("zero", 16'(e.z), 16'(zeroFlag));
            compare("next address", 16'(e.pc), 16'(progAddr));
            compare("irq enable", 16'(e.irq), 16'(globalIrqEnable));
        end
        if (instrDone === 1'b1)
            gap = 0;
    end

    // ------------------------------------------------------------
    // Program and expectations
    // ------------------------------------------------------------
    task automatic ins(input int addr, input op_t op, input logic [7:0] arg,
                       input logic [2:0] bitSel, input int gapCycles, input int nextPc);
        u_program_memory.words[addr] = {op, bitSel, arg};
        pending.push_back(expect_t'{gapCycles, 8'(nextPc), a, c, z, irq});
    endtask : ins

    task automatic load(input int run);
        for (int i = 0; i < 256; i++)
            u_program_memory.words[i] = 16'h0000;
        seed = xorshift(seed);
        r1 = (run == 0) ? 8'hFF : seed[7:0];
        r2 = (run == 0) ? 8'h01 : seed[15:8];
        r4 = seed[23:16];
        a = r1;
        c = 1'b0;
        z = 1'b0;
        irq = 1'b0;
        ins(0, OP_XFER_A_IMM, r1, 3'h0, 0, 1);
        m = r1;
        ins(1, OP_XFER_MEM_A, 8'h05, 3'h0, 4, 2);
        {c, a} = {1'b0, a} + {1'b0, r2};
        z = (a == 8'h00);
        ins(2, OP_ADD_A_IMM, r2, 3'h0, 4, 3);
        c = (a < m);
        a = a - m;
        z = (a == 8'h00);
        ins(3, OP_SUB_A_MEM, 8'h05, 3'h0, 4, 4);
        a = m + 8'h01;
        z = (a == 8'h00);
        ins(4, OP_ADD_ONE_ACC, 8'h05, 3'h0, 4, 5);
        m = m - 8'h01;
        z = (m == 8'h00);
        ins(5, OP_SUB_ONE_MEM, 8'h05, 3'h0, 4, 6);
        a = m;
        ins(6, OP_XFER_A_MEM, 8'h05, 3'h0, 4, 7);
        a = 8'h00;
        z = 1'b1;
        ins(7, OP_XOR_A_MEM, 8'h05, 3'h0, 4, 8);
        {c, m} = {m, c};
        ins(8, OP_ROT_LEFT_C, 8'h05, 3'h0, 4, 9);
        a = m;
        ins(9, OP_XFER_A_MEM, 8'h05, 3'h0, 4, 10);
        m[3] = 1'b1;
        ins(10, OP_SET_BIT, 8'h05, 3'h3, 4, 11);
        a = m;
        ins(11, OP_XFER_A_MEM, 8'h05, 3'h0, 4, 12);
        ins(12, OP_SKIP_BIT_SET, 8'h05, 3'h3, 8, 14);
        // Would corrupt acc if the skip were not honoured
        u_program_memory.words[13] = {OP_XFER_A_IMM, 3'h0, 8'h11};
        ins(14, OP_CALL, 8'h28, 3'h0, 8, 40);
        a = 8'h3C;
        ins(40, OP_XFER_A_IMM, 8'h3C, 3'h0, 4, 41);
        ins(41, OP_SUB_EXIT, 8'h00, 3'h0, 8, 15);
        ins(15, OP_SKIP_ZERO, 8'h05, 3'h0, 4, 16);
        ins(16, OP_JUMP, 8'h32, 3'h0, 8, 50);
        ins(50, OP_XFER_MEM_A, 8'h00, 3'h0, 8, 60);
        u_program_memory.words[200] = {r2, r4};
        a = r4;
        ins(60, OP_TABLE_READ, 8'hC8, 3'h0, 8, 61);
        c = (a < r2);
        a = a - r2;
        z = (a == 8'h00);
        ins(61, OP_SUB_A_IMM, r2, 3'h0, 4, 62);
        {m, c} = {c, m};
        ins(62, OP_ROT_RIGHT_C, 8'h05, 3'h0, 4, 63);
        hit = m[r4[2:0]];
        ins(63, OP_SKIP_BIT_CLR, 8'h05, r4[2:0], hit ? 4 : 8, hit ? 64 : 65);
        if (hit)
            ins(64, OP_NOP, 8'h00, 3'h0, 4, 65);
        a = a & m;
        z = (a == 8'h00);
        ins(65, OP_AND_A_MEM, 8'h05, 3'h0, 4, 66);
        a = a | m;
        z = (a == 8'h00);
        ins(66, OP_OR_A_MEM, 8'h05, 3'h0, 4, 67);
        a = ~m;
        z = (a == 8'h00);
        ins(67, OP_INVERT_ACC, 8'h05, 3'h0, 4, 68);
        m = ~m;
        z = (m == 8'h00);
        ins(68, OP_INVERT_MEM, 8'h05, 3'h0, 4, 69);
        m = {m[0], m[7:1]};
        ins(69, OP_ROT_RIGHT, 8'h05, 3'h0, 4, 70);
        m[r4[5:3]] = 1'b0;
        ins(70, OP_CLEAR_BIT, 8'h05, r4[5:3], 4, 71);
        m = {m[6:0], m[7]};
        ins(71, OP_ROT_LEFT, 8'h05, 3'h0, 4, 72);
        {c, a} = {1'b0, a} + {1'b0, m};
        z = (a == 8'h00);
        ins(72, OP_ADD_A_MEM, 8'h05, 3'h0, 4, 73);
        m = m + 8'h01;
        z = (m == 8'h00);
        ins(73, OP_ADD_ONE_MEM, 8'h05, 3'h0, 4, 74);
        a = m - 8'h01;
        z = (a == 8'h00);
        ins(74, OP_SUB_ONE_ACC, 8'h05, 3'h0, 4, 75);
        ins(75, OP_CLEAR_MEM, 8'h05, 3'h0, 4, 76);
        ins(76, OP_SKIP_ZERO, 8'h05, 3'h0, 8, 78);
        irq = 1'b1;
        ins(78, OP_IRQ_EXIT, 8'h00, 3'h0, 8, 15);
    endtask : load

    initial
    begin
        for (int run = 0; run < 3; run++)
        begin
            load(run);
            repeat (6) @(negedge clk);
            reset = 1'b0;
            for (int i = 0; i < 400 && pending.size() > 0; i++)
                @(negedge clk);
            if (pending.size() > 0)
            begin
                n_fail++;
                break;
            end
            reset = 1'b1;
        end
        summarize();
    end
endmodule : instruction_timing_execution_tb
